// File: core/sbo_bus_options.v
/*
 bus options register bank with status and receive size check.
 assumes a same-clock register master, one-cycle strobes, and that
 global_hw_reset_n comes from the pin and is synchronised here.
*/
// The address map and the strobed register port were decided locally.
// Summary of operation
// [RULE1] four writable capability flags at bits 31..28 reset to zero.
// [RULE2] bit 27 is a writable power-management flag resetting to zero.
// [RULE3] bits 26..24, 11..8 and 5..3 always read as zero.
// [RULE4] bits 23..16 hold the writable clock accuracy, reset zero.
// [RULE5] bits 15..12 hold the max request code; limit is 2^(code+1), at least 512.
// [RULE6] only global reset loads the code with A; soft reset keeps it.
// [RULE7] a block write longer than the limit may be answered with a type error.
// [RULE8] software keeps the fields valid while link_enable_ctl is one.
// [RULE9] bits 7..6 are a writable generation counter bumped at a bus reset after a rom change.
// [RULE10] bits 2..0 always read 010.
// [RULE11] writes to reserved and read-only bits are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "sbo_regs.vh"

module sbo_bus_options #(
    parameter LEN_W = `SBO_LEN_W
) (
    // clock and resets
    input wire sys_clk_in,
    input wire nrst_in,
    input wire global_hw_reset_n_in,
    // register port
    input wire [`SBO_ADDR_W-1:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    // link side
    input wire link_enable_ctl_in,
    input wire rom_changed_in,
    input wire bus_reset_in,
    input wire rx_write_valid_in,
    input wire [LEN_W-1:0] rx_write_len_in,
    output reg rx_type_error_out,
    output wire [31:0] bus_options_out
);
    reg ghr_meta;
    reg ghr_sync;
    reg ghr_seen;
    reg [4:0] caps;
    reg [7:0] accuracy;
    reg [3:0] max_rec;
    reg size_check_en;
    reg invalid_rec_seen;
    wire [1:0] gen;
    wire gen_dirty;
    wire too_long;
    wire [31:0] options;
    wire opt_wr;
    wire rec_invalid;

    // global reset arrives from a pin, so two flops first
    always @(posedge sys_clk_in) begin
        ghr_meta <= global_hw_reset_n_in;
        ghr_sync <= ghr_meta;
    end

    assign opt_wr = wr_in && (addr_in == `SBO_OFS_OPTIONS);

    // soft reset (nrst_in) deliberately skips max_rec
    always @(posedge sys_clk_in) begin
        if (!ghr_sync) begin
            max_rec <= `SBO_REC_RESET; // [RULE6]
            ghr_seen <= 1'b1;
        end else begin
            if (opt_wr && nrst_in) begin
                max_rec <= wdata_in[`SBO_REC_HI:`SBO_REC_LO]; // [RULE5]
            end
            if (wr_in && nrst_in && addr_in == `SBO_OFS_STATUS && wdata_in[0]) begin
                ghr_seen <= 1'b0;
            end
        end
    end

    always @(posedge sys_clk_in) begin
        if (!nrst_in || !ghr_sync) begin
            caps <= `SBO_CAP_RESET; // [RULE1] [RULE2]
            accuracy <= `SBO_ACC_RESET; // [RULE4]
            size_check_en <= 1'b0;
        end else begin
            if (opt_wr) begin
                caps <= wdata_in[`SBO_BIT_IRMC:`SBO_BIT_PMC]; // [RULE1] [RULE2]
                accuracy <= wdata_in[`SBO_ACC_HI:`SBO_ACC_LO]; // [RULE4]
            end
            if (wr_in && addr_in == `SBO_OFS_CHECK) begin
                size_check_en <= wdata_in[0];
            end
        end
    end

    sbo_gen_counter u_gen (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in && ghr_sync),
        .wr_in(opt_wr),
        .wdata_in(wdata_in[`SBO_GEN_HI:`SBO_GEN_LO]),
        .rom_changed_in(rom_changed_in),
        .bus_reset_in(bus_reset_in),
        .gen_out(gen),
        .dirty_out(gen_dirty)
    );

    // reserved bits are constant zero, speed constant
    assign options = {caps, 3'b000, accuracy, max_rec, 4'b0000,
                      gen, 3'b000, `SBO_LINK_SPEED}; // [RULE3] [RULE10] [RULE11]
    assign bus_options_out = options;

    // codes below 8 break the 512-byte floor
    assign rec_invalid = (max_rec < `SBO_REC_MIN); // [RULE5]

    // a bad code seen while the link runs flags a host fault
    always @(posedge sys_clk_in) begin
        if (!nrst_in || !ghr_sync) begin
            invalid_rec_seen <= 1'b0;
        end else if (link_enable_ctl_in && rec_invalid) begin
            invalid_rec_seen <= 1'b1; // [RULE8]
        end else if (wr_in && addr_in == `SBO_OFS_STATUS && wdata_in[1]) begin
            invalid_rec_seen <= 1'b0;
        end
    end

    sbo_size_check #(
        .LEN_W(LEN_W)
    ) u_size (
        .max_rec_in(max_rec),
        .len_in(rx_write_len_in),
        .too_long_out(too_long)
    );

    always @(posedge sys_clk_in) begin
        if (!nrst_in || !ghr_sync) begin
            rx_type_error_out <= 1'b0;
        end else begin
            rx_type_error_out <= rx_write_valid_in && size_check_en && too_long; // [RULE7]
        end
    end

    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                `SBO_OFS_OPTIONS: rdata_out <= options;
                `SBO_OFS_STATUS: rdata_out <= {27'h000_0000, link_enable_ctl_in,
                                               gen_dirty, rec_invalid,
                                               invalid_rec_seen, ghr_seen};
                `SBO_OFS_CHECK: rdata_out <= {31'h0000_0000, size_check_en};
                default: rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// File: include/sbo_regs.vh
/*
 bus options register constants: offsets, field positions, reset values.
 assumes inclusion by the block's design files only.
*/
`ifndef SBO_REGS_VH
`define SBO_REGS_VH

`define SBO_ADDR_W 8
`define SBO_OFS_OPTIONS 8'h00
`define SBO_OFS_STATUS 8'h04
`define SBO_OFS_CHECK 8'h08
`define SBO_BIT_IRMC 31
`define SBO_BIT_CMC 30
`define SBO_BIT_ISC 29
`define SBO_BIT_BMC 28
`define SBO_BIT_PMC 27
`define SBO_ACC_HI 23
`define SBO_ACC_LO 16
`define SBO_REC_HI 15
`define SBO_REC_LO 12
`define SBO_GEN_HI 7
`define SBO_GEN_LO 6
`define SBO_SPD_HI 2
`define SBO_SPD_LO 0
`define SBO_WMASK 32'hF8FF_F0C0
`define SBO_LINK_SPEED 3'h2
`define SBO_REC_RESET 4'hA
`define SBO_REC_MIN 4'h8
`define SBO_CAP_RESET 5'h00
`define SBO_ACC_RESET 8'h00
`define SBO_GEN_RESET 2'h0
`define SBO_LEN_W 16

`endif

// File: core/sbo_size_check.v
/*
 compares a received block write length against the byte limit
 implied by the maximum request code.
 assumes a length and a code that are stable in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbo_regs.vh"

module sbo_size_check #(
    parameter LEN_W = `SBO_LEN_W
) (
    // inputs
    input wire [3:0] max_rec_in,
    input wire [LEN_W-1:0] len_in,
    // outputs
    output wire too_long_out
);
    wire [4:0] pow;
    wire [LEN_W+15:0] limit;

    // limit = 2^(code+1) bytes; pow and limit are wide enough that code 15 gives 2^16 without wrapping
    assign pow = {1'b0, max_rec_in} + 5'h01;
    assign limit = {{(LEN_W+15){1'b0}}, 1'b1} << pow; // [RULE5]
    assign too_long_out = ({16'h0000, len_in} > limit); // [RULE7]
endmodule
`default_nettype wire

// File: core/sbo_gen_counter.v
/*
 two-bit generation counter: host may write it, hardware bumps it
 at a bus reset when the configuration rom changed since the last one.
 assumes single-cycle pulses on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sbo_regs.vh"

module sbo_gen_counter (
    // clock and reset
    input wire sys_clk_in,
    input wire nrst_in,
    // control
    input wire wr_in,
    input wire [1:0] wdata_in,
    input wire rom_changed_in,
    input wire bus_reset_in,
    // state
    output reg [1:0] gen_out,
    output reg dirty_out
);
    always @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            gen_out <= `SBO_GEN_RESET;
            dirty_out <= 1'b0;
        end else begin
            if (wr_in) begin
                gen_out <= wdata_in;
            end else if (bus_reset_in && (dirty_out || rom_changed_in)) begin
                gen_out <= gen_out + 2'h1; // [RULE9]
            end
            // a change in the reset cycle itself bumps this reset, then clears
            if (bus_reset_in) begin
                dirty_out <= 1'b0;
            end else if (rom_changed_in) begin
                dirty_out <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: test/sbo_bus_options_props.sv
/* port checker for the bus options bank.
 assumes the bind below onto sbo_bus_options. */
`timescale 1ns/1ps
`default_nettype none
module sbo_chk (
    // watched ports
    input wire sys_clk_in,
    input wire nrst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire rx_write_valid_in,
    input wire rx_type_error_out,
    input wire [31:0] bus_options_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    wire wo = wr_in && addr_in == 8'h00;
    chk_speed_fixed: assert property (bus_options_out[2:0] == 3'b010)
        else $error("speed code");
    chk_rsvd_zero: assert property ((bus_options_out & 32'h0700_0F38) == 0)
        else $error("reserved bits");
    chk_field_write: assert property (wo |=> (bus_options_out & 32'hF8FF_F000) ==
        ($past(wdata_in) & 32'hF8FF_F000)) else $error("field write");
    chk_gen_write: assert property (wo |=> bus_options_out[7:6] == $past(wdata_in[7:6]))
        else $error("generation write");
    chk_fields_hold: assert property (!wo |=> $stable(bus_options_out[31:8]))
        else $error("fields moved");
    chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 0)
        else $error("rdata idle");
    chk_rdata_value: assert property (rd_in && addr_in == 0 |=> rdata_out == $past(bus_options_out))
        else $error("rdata value");
    chk_err_cause: assert property (rx_type_error_out |-> $past(rx_write_valid_in))
        else $error("stray error");
endmodule
bind sbo_bus_options sbo_chk sbo_chk_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .rx_write_valid_in(rx_write_valid_in), .rx_type_error_out(rx_type_error_out),
    .bus_options_out(bus_options_out));
`default_nettype wire

// File: test/sbo_node.sv
/* remote node model: hands block write requests to the link side.
 assumes one-cycle send_in pulses from the bench. */
`timescale 1ns/1ps
`default_nettype none
module sbo_node (
    // request
    input wire sys_clk_in,
    input wire send_in,
    input wire [15:0] len_in,
    // link side
    output logic valid_out = 1'b0,
    output logic [15:0] len_out = 16'h0000
);
    always @(posedge sys_clk_in) begin
        valid_out <= send_in;
        // length is garbage once the packet is gone
        len_out <= send_in ? len_in : ~len_out;
    end
endmodule
`default_nettype wire

// File: test/testbench.sv
/* bench for the bus options bank: register traffic, size check, resets.
 assumes the node model and the bound checker compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, nrst = 0, ngrst = 0, we = 0, re = 0, le = 0, rc = 0, br = 0, snd = 0, rv, terr;
    logic [7:0] a = 8'h00;
    logic [15:0] ln = 16'h0000, rl;
    logic [31:0] wd = 32'h0000_0000, d, rdata, opts;
    int fails = 0, comparisons = 0, cyc = 0, i;
    initial forever #2.5 clk = ~clk;
    sbo_node sbo_node_inst (.sys_clk_in(clk), .send_in(snd), .len_in(ln), .valid_out(rv),
        .len_out(rl));
    sbo_bus_options sbo_bus_options_inst (.sys_clk_in(clk), .nrst_in(nrst),
        .global_hw_reset_n_in(ngrst), .addr_in(a), .wdata_in(wd), .wr_in(we), .rd_in(re),
        .rdata_out(rdata), .link_enable_ctl_in(le), .rom_changed_in(rc), .bus_reset_in(br),
        .rx_write_valid_in(rv), .rx_write_len_in(rl), .rx_type_error_out(terr),
        .bus_options_out(opts));
    function logic [15:0] lim(input int c);
        return 16'(1 << (c + 1));
    endfunction
    task summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, v);
        end
    endtask
    task bus(input logic [7:0] ad, input logic [31:0] dt, input logic w, input logic r);
        @(posedge clk);
        a <= ad;
        wd <= dt;
        we <= w;
        re <= r;
        @(posedge clk);
        we <= 0;
        re <= 0;
        #1;
    endtask
    task rd(input logic [7:0] ad, input logic [31:0] e);
        bus(ad, 32'h0000_0000, 0, 1);
        cmp("rdata", e, rdata);
    endtask
    task ev(input logic r, input logic b);
        @(posedge clk);
        rc <= r;
        br <= b;
        @(posedge clk);
        rc <= 0;
        br <= 0;
        #1;
    endtask
    task sz(input logic [15:0] l, input logic e);
        @(posedge clk);
        snd <= 1;
        ln <= l;
        @(posedge clk);
        snd <= 0;
        @(posedge clk);
        #1 cmp("type_error", {31'h0, e}, {31'h0, terr});
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hb81da5a8));
        repeat (3) @(posedge clk);
        ngrst <= 1;
        repeat (3) @(posedge clk);
        nrst <= 1;
        repeat (3) @(posedge clk);
        #1 cmp("reset", 32'h0000_A002, opts);
        rd(8'h00, 32'h0000_A002);
        rd(8'h40, 32'h0000_0000);
        rd(8'h04, 32'h0000_0001);
        bus(8'h04, 32'h0000_0001, 1, 0);
        rd(8'h04, 32'h0000_0000);
        for (i = 0; i < 24; i++) begin
            d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
            bus(8'h00, d, 1, 0);
            cmp("options", d & 32'hF8FF_F0C0 | 32'h0000_0002, opts);
            rd(8'h00, d & 32'hF8FF_F0C0 | 32'h0000_0002);
        end
        $display("register test done");
        bus(8'h08, 32'h0000_0001, 1, 0);
        for (i = 8; i < 16; i++) begin
            bus(8'h00, i << 12, 1, 0);
            le <= 1;
            sz(i == 15 ? 16'hFFFF : lim(i), 1'b0);
            if (i < 15)
                sz(lim(i) + 16'h0001, 1'b1);
        end
        le <= 0;
        $display("size test done");
        bus(8'h00, 32'h0000_0000, 1, 0);
        ev(1, 0);
        ev(0, 1);
        cmp("generation", 32'h0000_0042, opts);
        ev(0, 1);
        cmp("generation", 32'h0000_0042, opts);
        bus(8'h00, 32'h0000_00C0, 1, 0);
        ev(1, 0);
        ev(0, 1);
        cmp("generation", 32'h0000_0002, opts);
        $display("generation test done");
        bus(8'h00, 32'hFFFF_5FFF, 1, 0);
        nrst <= 0;
        @(posedge clk);
        nrst <= 1;
        #1 cmp("soft_reset", 32'h0000_5002, opts);
        $display("soft reset test done");
        summarize();
    end
endmodule
`default_nettype wire
